// ### hw/acc_chain_regs.sv
// Top of the acquisition chain control and low status register bank
`timescale 1ns/1ps
module acc_chain_regs
    import acc_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire acc_req_t busReq,
    output logic [15:0] rdata,
    output logic rdValid,
    output logic accessError,
    input wire logic normalMode,
    input wire logic shuntOpenDetectEnable,
    input wire logic shuntOpenRaw,
    input wire logic voltageResultValid,
    input wire logic [15:0] voltageResult,
    input wire logic [3:0] chopperActive,
    output acc_chain_t chainCtrl
);
    ////////////////////////////////////////////////////////////////////////////////
    // Decode
    function automatic logic inWindow(input logic [15:0] a, input logic [7:0] ofs);
        logic baseHit;
        baseHit = ((a & ACC_BASE_MASK) == ACC_BASE_BLOCKING) ||
                  ((a & ACC_BASE_MASK) == ACC_BASE_NONBLOCKING);
        return baseHit && ((a[7:0] & ACC_OFS_WINDOW_MASK) == ofs);
    endfunction

    logic hitChain;
    logic hitStatus;
    logic [7:0] statusByte;
    logic [7:0] chain_reg;
    logic [7:0] chain_next;
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;
    logic rdValid_reg;
    logic rdValid_next;
    logic err_reg;
    logic err_next;

    assign hitChain = inWindow(busReq.addr, ACC_OFS_CHAIN_CTRL_ONE);
    assign hitStatus = inWindow(busReq.addr, ACC_OFS_STATUS_LOW);

    acc_status_low uStatus (
        .core_clk(core_clk),
        .reset(reset),
        .normalMode(normalMode),
        .shuntOpenDetectEnable(shuntOpenDetectEnable),
        .shuntOpenRaw(shuntOpenRaw),
        .voltageResultValid(voltageResultValid),
        .voltageResult(voltageResult),
        .chopperActive(chopperActive),
        .statusByte(statusByte)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Masked write of each setting bit; byte writes are refused whole
    always_comb begin
        chain_next = chain_reg;
        err_next = 1'b0;
        if (busReq.wr && hitChain) begin
            if (!busReq.wordAccess) begin
                err_next = 1'b1;
            end else begin
                for (int i = 0; i < 8; i++) begin
                    // Mask i+8 gates bit i, so mask 12 gates the filter enable
                    if (busReq.wdata[i + ACC_MASK_SHIFT]) begin
                        chain_next[i] = busReq.wdata[i];
                    end
                end
            end
        end else if (busReq.rd && hitChain && !busReq.wordAccess) begin
            err_next = 1'b1;
        end
    end

    // Read path: mask half reads zero, status ignores writes
    always_comb begin
        rdata_next = 16'h0000;
        rdValid_next = 1'b0;
        if (busReq.rd) begin
            rdValid_next = 1'b1;
            if (hitChain && busReq.wordAccess) begin
                rdata_next = {8'h00, chain_reg};
            end else if (hitStatus) begin
                rdata_next = {8'h00, statusByte};
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            chain_reg <= ACC_CHAIN_RESET;
            rdata_reg <= 16'h0000;
            rdValid_reg <= 1'b0;
            err_reg <= 1'b0;
        end else begin
            chain_reg <= chain_next;
            rdata_reg <= rdata_next;
            rdValid_reg <= rdValid_next;
            err_reg <= err_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Settings out to the analog chain
    assign chainCtrl.tempCompensationEnable = chain_reg[ACC_BIT_TEMP_COMP];
    assign chainCtrl.voltageCompensationEnable = chain_reg[ACC_BIT_VOLT_COMP];
    assign chainCtrl.currentCompensationEnable = chain_reg[ACC_BIT_CURR_COMP];
    assign chainCtrl.lowpassFilterEnable = chain_reg[ACC_BIT_LPF];
    assign chainCtrl.extTempChopper = chain_reg[ACC_BIT_EXT_CHOP];
    assign chainCtrl.intTempChopper = chain_reg[ACC_BIT_INT_CHOP];
    assign chainCtrl.voltageChopperEnable = chain_reg[ACC_BIT_VOLT_CHOP];
    // Gain stage uses the manual gain field whenever this is low
    assign chainCtrl.autoGainEnable = chain_reg[ACC_BIT_AUTO_GAIN];

    assign rdata = rdata_reg;
    assign rdValid = rdValid_reg;
    assign accessError = err_reg;
endmodule

// ### hw/acc_pkg.sv
// Package with offsets, field positions and reset values for the acquisition chain register bank
package acc_pkg;
    ////////////////////////////////////////////////////////////////////////////////
    // Address map
    localparam logic [15:0] ACC_BASE_BLOCKING = 16'h0200;
    localparam logic [15:0] ACC_BASE_NONBLOCKING = 16'h0300;
    localparam logic [7:0] ACC_OFS_STATUS_LOW = 8'h5B;
    localparam logic [7:0] ACC_OFS_CHAIN_CTRL_ONE = 8'h5C;
    localparam logic [7:0] ACC_OFS_WINDOW_MASK = 8'hFF;
    localparam logic [15:0] ACC_BASE_MASK = 16'hFF00;

    ////////////////////////////////////////////////////////////////////////////////
    // Field positions of the chain control register
    localparam int ACC_MASK_SHIFT = 8;
    localparam int ACC_BIT_TEMP_COMP = 7;
    localparam int ACC_BIT_VOLT_COMP = 6;
    localparam int ACC_BIT_CURR_COMP = 5;
    localparam int ACC_BIT_LPF = 4;
    localparam int ACC_BIT_EXT_CHOP = 3;
    localparam int ACC_BIT_INT_CHOP = 2;
    localparam int ACC_BIT_VOLT_CHOP = 1;
    localparam int ACC_BIT_AUTO_GAIN = 0;
    localparam logic [7:0] ACC_CHAIN_RESET = 8'hE1;

    // Field positions of the low status byte
    localparam int ACC_BIT_OPEN = 7;
    localparam int ACC_BIT_VHIGH = 4;
    localparam logic [15:0] ACC_VOLT_THRESHOLD = 16'hDAC0;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus request and chain settings
    typedef struct packed {
        logic rd;
        logic wr;
        logic wordAccess;
        logic [15:0] addr;
        logic [15:0] wdata;
    } acc_req_t;

    typedef struct packed {
        logic tempCompensationEnable;
        logic voltageCompensationEnable;
        logic currentCompensationEnable;
        logic lowpassFilterEnable;
        logic extTempChopper;
        logic intTempChopper;
        logic voltageChopperEnable;
        logic autoGainEnable;
    } acc_chain_t;
endpackage

// ### hw/acc_status_low.sv
// Read-only low status byte assembly
`timescale 1ns/1ps
module acc_status_low
    import acc_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic normalMode,
    input wire logic shuntOpenDetectEnable,
    input wire logic shuntOpenRaw,
    input wire logic voltageResultValid,
    input wire logic [15:0] voltageResult,
    input wire logic [3:0] chopperActive,
    output logic [7:0] statusByte
);
    logic vHigh_reg;
    logic vHigh_next;
    logic [7:0] status_reg;
    logic [7:0] status_next;

    // Threshold flag follows the latest valid result on the single voltageResult input
    always_comb begin
        vHigh_next = vHigh_reg;
        if (voltageResultValid) begin
            vHigh_next = (voltageResult >= ACC_VOLT_THRESHOLD);
        end
        status_next = 8'h00;
        // Open flag only meaningful in normal mode with detection enabled
        status_next[ACC_BIT_OPEN] = shuntOpenRaw & normalMode & shuntOpenDetectEnable;
        status_next[ACC_BIT_VHIGH] = vHigh_next;
        status_next[3:0] = chopperActive;
    end

    // Registered so the read data never glitches
    always_ff @(posedge core_clk) begin
        if (reset) begin
            vHigh_reg <= 1'b0;
            status_reg <= 8'h00;
        end else begin
            vHigh_reg <= vHigh_next;
            status_reg <= status_next;
        end
    end

    assign statusByte = status_reg;
endmodule

// ### verification/acc_chain_regs_monitor.sv
// Port checker for the acquisition chain register bank
`timescale 1ns/1ps
module acc_chain_regs_monitor
    import acc_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire acc_req_t busReq,
    input wire logic [15:0] rdata,
    input wire logic rdValid,
    input wire logic accessError,
    input wire logic normalMode,
    input wire logic shuntOpenDetectEnable,
    input wire logic shuntOpenRaw,
    input wire logic voltageResultValid,
    input wire logic [15:0] voltageResult,
    input wire logic [3:0] chopperActive,
    input wire acc_chain_t chainCtrl
);
default clocking @(posedge core_clk); endclocking
default disable iff (reset);
// Both bases alias the same window
wire logic baseHit = busReq.addr[15:8] inside {8'h02, 8'h03};
wire logic ctrlHit = baseHit && busReq.addr[7:0] == ACC_OFS_CHAIN_CTRL_ONE;
wire logic statRd = busReq.rd && baseHit && busReq.addr[7:0] == ACC_OFS_STATUS_LOW;
logic [1:0] up_reg, up_next;
logic vRef_reg, vRef_next;
// Status register is cleared by reset, so trust it only a few cycles later
always_comb begin
    up_next = reset ? 2'd0 : (up_reg == 2'd3 ? up_reg : up_reg + 2'd1);
    vRef_next = reset ? 1'b0 : (voltageResultValid ? voltageResult >= ACC_VOLT_THRESHOLD : vRef_reg);
end
always_ff @(posedge core_clk) begin
    up_reg <= up_next;
    vRef_reg <= vRef_next;
end
////////////////////////////////////////////////////////////////////////////////
property p_rd_valid; busReq.rd |=> rdValid; endproperty
a_rd_valid: assert property (p_rd_valid) else $error("no rdValid");
property p_unmapped; busReq.rd && !baseHit |=> rdata == 16'h0000; endproperty
a_unmapped: assert property (p_unmapped) else $error("unmapped data");
property p_byte; (busReq.rd || busReq.wr) && !busReq.wordAccess && ctrlHit |=> accessError && $stable(chainCtrl); endproperty
a_byte: assert property (p_byte) else $error("byte access");
property p_merge; busReq.wr && busReq.wordAccess && ctrlHit |=> chainCtrl == (($past(chainCtrl) &
    ~$past(busReq.wdata[15:8])) | ($past(busReq.wdata[7:0]) & $past(busReq.wdata[15:8]))); endproperty
a_merge: assert property (p_merge) else $error("mask merge");
property p_ctrl_rd; busReq.rd && !busReq.wr && busReq.wordAccess && ctrlHit |=> rdata == {8'h00, $past(chainCtrl)}; endproperty
a_ctrl_rd: assert property (p_ctrl_rd) else $error("ctrl read");
property p_vth; up_reg == 2'd3 && !voltageResultValid [*3] ##0 statRd |=> rdata[ACC_BIT_VHIGH] == $past(vRef_reg); endproperty
a_vth: assert property (p_vth) else $error("threshold bit");
property p_chop; up_reg == 2'd3 && $stable(chopperActive) [*3] ##0 statRd |=> rdata[3:0] == $past(chopperActive); endproperty
a_chop: assert property (p_chop) else $error("chopper bits");
property p_open; up_reg == 2'd3 && $stable({normalMode, shuntOpenDetectEnable, shuntOpenRaw}) [*3] ##0 statRd
    |=> rdata[7:5] == {$past(normalMode && shuntOpenDetectEnable && shuntOpenRaw), 2'b00}; endproperty
a_open: assert property (p_open) else $error("open bit");
endmodule

// ### verification/testbench.sv
// Self-checking bench for the acquisition chain register bank
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; $display("mismatch %s exp %h got %h", n, e, g); end end
module testbench
    import acc_pkg::*;
;
logic core_clk = 0, reset = 1, normalMode = 0, shuntOpenDetectEnable = 0, shuntOpenRaw = 0, voltageResultValid = 0;
logic [15:0] voltageResult = 16'h0000, rdata, q;
logic [3:0] chopperActive = 4'h0;
logic rdValid, accessError;
acc_req_t busReq = '0;
acc_chain_t chainCtrl;
logic [7:0] expC = 8'hE1;
int n_fail = 0, n_checks = 0;
acc_chain_regs dut (
    .core_clk(core_clk),
    .reset(reset),
    .busReq(busReq),
    .rdata(rdata),
    .rdValid(rdValid),
    .accessError(accessError),
    .normalMode(normalMode),
    .shuntOpenDetectEnable(shuntOpenDetectEnable),
    .shuntOpenRaw(shuntOpenRaw),
    .voltageResultValid(voltageResultValid),
    .voltageResult(voltageResult),
    .chopperActive(chopperActive),
    .chainCtrl(chainCtrl)
);
// 50 MHz clock
initial begin
    forever #10 core_clk = ~core_clk;
end
task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
        $display("TB: PASS");
    end else begin
        $display("TB: FAIL");
    end
    $finish;
endtask
// One access, held for exactly one rising edge; a gap cycle keeps strobes from being set twice at once
task automatic xfer(input logic r, input logic [15:0] a, input logic [15:0] d, input logic w, input logic e);
    @(negedge core_clk);
    busReq = '{rd: r, wr: !r, wordAccess: w, addr: a, wdata: d};
    @(negedge core_clk);
    busReq.rd = 1'b0;
    busReq.wr = 1'b0;
    q = rdata;
    `CHK("rdValid", r, rdValid)
    `CHK("accessError", e, accessError)
endtask
////////////////////////////////////////////////////////////////////////////////
// Main sequence
initial begin
    repeat (10) @(negedge core_clk);
    reset = 1'b0;
    xfer(1, 16'h025C, 16'h0000, 1, 0);
    `CHK("ctrlReset", {8'h00, expC}, q)
    xfer(0, 16'h025C, 16'h00FF, 1, 0);
    `CHK("masksOff", expC, chainCtrl)
    // Flip each setting alone under its own mask
    for (int i = 0; i < 8; i++) begin
        xfer(0, 16'h035C, {8'h01 << i, ~expC & (8'h01 << i)}, 1, 0);
        expC[i] = ~expC[i];
        `CHK("ctrlPort", expC, chainCtrl)
        xfer(1, 16'h035C, 16'h0000, 1, 0);
        `CHK("ctrlRead", {8'h00, expC}, q)
    end
    xfer(0, 16'h025C, 16'hFFFF, 0, 1);
    xfer(1, 16'h025C, 16'h0000, 0, 1);
    `CHK("byteRead", 16'h0000, q)
    `CHK("byteWrite", expC, chainCtrl)
    // Second reset in mid-run must bring every setting back to its reset value
    reset = 1'b1;
    @(negedge core_clk);
    @(negedge core_clk);
    reset = 1'b0;
    expC = ACC_CHAIN_RESET;
    `CHK("ctrlAfterReset", expC, chainCtrl)
    xfer(1, 16'h025C, 16'h0000, 1, 0);
    `CHK("ctrlReadAfterReset", {8'h00, expC}, q)
    shuntOpenRaw = 1'b1;
    // Threshold at, below and above the limit; detection on, then off, then outside normal mode
    for (int k = 0; k < 3; k++) begin
        normalMode = (k != 2);
        shuntOpenDetectEnable = (k != 1);
        chopperActive = (k == 0) ? 4'hA : ((k == 1) ? 4'h5 : 4'h3);
        voltageResult = (k == 0) ? ACC_VOLT_THRESHOLD : ((k == 1) ? 16'hDABF : 16'hFFFF);
        voltageResultValid = 1'b1;
        @(negedge core_clk);
        voltageResultValid = 1'b0;
        xfer(0, 16'h025B, 16'hFFFF, 0, 0);
        xfer(1, 16'h035B, 16'h0000, 0, 0);
        `CHK("status", (k == 0) ? 8'h9A : ((k == 1) ? 8'h05 : 8'h13), q[7:0])
    end
    xfer(1, 16'h045C, 16'h0000, 1, 0);
    `CHK("unmapped", 16'h0000, q)
    complete_run();
end
// Watchdog against a stuck run
initial begin
    #1000000;
    n_fail++;
    complete_run();
end
endmodule
bind acc_chain_regs acc_chain_regs_monitor mon (
    .core_clk(core_clk),
    .reset(reset),
    .busReq(busReq),
    .rdata(rdata),
    .rdValid(rdValid),
    .accessError(accessError),
    .normalMode(normalMode),
    .shuntOpenDetectEnable(shuntOpenDetectEnable),
    .shuntOpenRaw(shuntOpenRaw),
    .voltageResultValid(voltageResultValid),
    .voltageResult(voltageResult),
    .chopperActive(chopperActive),
    .chainCtrl(chainCtrl)
);
